// ---- rtl/srn_node_core.sv ----
// Ring node core: error screen, FIFOs, arbitration, protection, CSRs
//
// Summary of operation
// R1: Drop erroneous transfers, flag error interrupt
// R2: Redundant mode sends each transfer twice
// R3: Use first copy, second only on error
// R4: Both copies bad: drop the transfer
// R5: Byte, word, or both swap on host data
// R6: Reset state mirrors with no swap
// R7: Good ring data via RX FIFO, priority
// R8: Host writes go to memory and TX
// R9: Status flag while TX FIFO half full
// R10: Host pauses writes while half flag set
// R11: TX FIFO full: host write gets stop
// R12: RX over half: all host writes stopped
// R13: 256 segments of 256 Kbyte each
// R14: Protection map bars node per segment
// R15: Host fills map before enabling protection
// R16: Record faulting ID and segment, interrupt
// R17: Blocked writes still forwarded downstream
// R18: Own transfer returning sets status flag
// R19: Monitor mode refuses host writes
// R20: Disconnect isolates memory from ring
// R21: Capture upstream neighbour node ID
// R22: Initiator bitmap, software may overwrite
// R23: Lowest 0x40 bytes are CSR window
// R24: Jumper limits network to first 16 Mbyte
`timescale 1ns/1ns
`default_nettype none
`include "srn_params.svh"
module srn_node_core #(
	parameter int TX_DEPTH = 1024,
	parameter int RX_DEPTH = 64
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic      [1:0]  s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	input  wire logic        hostWrReq,
	input  wire logic [25:0] hostWrAddr,
	input  wire logic [31:0] hostWrData,
	output logic             hostWrAck,
	output logic             hostWrStop,
	input  wire logic [7:0]  nodeIdPin,
	input  wire logic        addrLimitPin,
	input  wire logic        linkRxClk,
	input  wire logic        rxValid,
	input  wire logic        rxErr,
	input  wire logic        rxCopy,
	input  wire logic [7:0]  rxHopId,
	input  wire logic [7:0]  rxSrcId,
	input  wire logic [25:0] rxAddr,
	input  wire logic [31:0] rxData,
	input  wire logic        linkTxClk,
	output logic             txValid,
	output logic             txCopy,
	output logic      [7:0]  txSrcId,
	output logic      [25:0] txAddr,
	output logic      [31:0] txData,
	output logic             memWrEn,
	output logic      [25:0] memWrAddr,
	output logic      [31:0] memWrData,
	output logic             hostIrq
);
	localparam int TXW = $clog2(TX_DEPTH);
	localparam int RXW = $clog2(RX_DEPTH);

	logic [76:0]            rxS1_r, rxS2_r;
	logic [8:0]             cfgS1_r, cfgS2_r;
	logic [2:0]             rxClk_r, txClk_r;
	logic                   rxEdge, txEdge, rxTake;
	logic [7:0]             nodeId, srcId;
	logic                   addrLimit;
	logic [7:0]             ctrl_r;
	logic                   redundant, monitor, disc, protEn;
	srn_pkg::srn_rxst_t     rxSt_r, rxSt_nxt;
	srn_pkg::srn_txst_t     txSt_r;
	logic                   rxAccept, rxOwn, rxPush;
	logic                   rxInReady, rxOutValid, txInReady, txOutValid;
	logic [65:0]            rxOutData, txItem, txOutData;
	logic [RXW:0]           rxCount;
	logic [TXW:0]           txCount;
	logic                   txHalf, rxStop_r;
	logic                   rxPop, txPush, txPop, memWe, hostMemWe;
	logic                   hostCsr, hostNet, blocked;
	logic [25:0]            memA;
	logic [31:0]            memD;
	logic [255:0]           protMap [256];
	logic [255:0]           initList_r;
	logic [2:0]             initIdx_r;
	logic [7:0]             upId_r, faultId_r, faultSeg_r;
	logic                   ownFlag_r, errFlag_r, protFlag_r;
	logic                   awHeld_r, wHeld_r, wrEn, wrOk;
	logic [7:0]             awAddr_r;
	logic [31:0]            wData_r, stWord, rdWord;
	logic [3:0]             wStrb_r;

	if (TX_DEPTH < 4 || RX_DEPTH < 4) begin : g_bad
		$error("srn_node_core: FIFO depths must be at least 4");
	end

	// Byte-lane merge for AXI write strobes
	function automatic logic [31:0] srnMerge(logic [31:0] o, logic [31:0] n, logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Lane steering of host data
	function automatic logic [31:0] srnSwap(srn_pkg::srn_swap_t m, logic [31:0] d);
		unique case (m)
			srn_pkg::SRN_SW_NONE: return d;
			srn_pkg::SRN_SW_BYTE: return {d[23:16], d[31:24], d[7:0], d[15:8]};
			srn_pkg::SRN_SW_WORD: return {d[15:0], d[31:16]};
			srn_pkg::SRN_SW_BOTH: return {d[7:0], d[15:8], d[23:16], d[31:24]};
		endcase
	endfunction

	// Pin synchronisers; the link clocks are sampled and edge-detected, never used as clocks
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rxS1_r  <= '0;
			rxS2_r  <= '0;
			cfgS1_r <= '0;
			cfgS2_r <= '0;
			rxClk_r <= '0;
			txClk_r <= '0;
		end else begin
			rxS1_r  <= {rxValid, rxErr, rxCopy, rxHopId, rxSrcId, rxAddr, rxData};
			rxS2_r  <= rxS1_r;
			cfgS1_r <= {addrLimitPin, nodeIdPin};
			cfgS2_r <= cfgS1_r;
			rxClk_r <= {rxClk_r[1:0], linkRxClk};
			txClk_r <= {txClk_r[1:0], linkTxClk};
		end
	end

	assign rxEdge    = rxClk_r[1] && !rxClk_r[2];
	assign txEdge    = txClk_r[1] && !txClk_r[2];
	assign rxTake    = rxEdge && rxS2_r[76];
	assign srcId     = rxS2_r[65:58];
	assign nodeId    = cfgS2_r[7:0];
	assign addrLimit = cfgS2_r[8];
	assign redundant = ctrl_r[`SRN_CTRL_RED];
	assign monitor   = ctrl_r[`SRN_CTRL_MON];
	assign disc      = ctrl_r[`SRN_CTRL_DISC];
	assign protEn    = ctrl_r[`SRN_CTRL_PROT];

	// Error screen and redundant-copy selection
	always_comb begin
		rxAccept = 1'b0;
		rxSt_nxt = rxSt_r;
		if (rxTake) begin
			if (!redundant) begin
				rxAccept = !rxS2_r[75]; // R1
				rxSt_nxt = srn_pkg::SRN_RX_IDLE;
			end else if (!rxS2_r[74]) begin
				rxAccept = !rxS2_r[75]; // R3
				rxSt_nxt = rxS2_r[75] ? srn_pkg::SRN_RX_WAIT2 : srn_pkg::SRN_RX_SKIP2;
			end else begin
				unique case (rxSt_r)
					srn_pkg::SRN_RX_SKIP2: rxAccept = 1'b0; // R3
					srn_pkg::SRN_RX_WAIT2: rxAccept = !rxS2_r[75]; // R4
					srn_pkg::SRN_RX_IDLE:  rxAccept = !rxS2_r[75];
					default:               rxAccept = 1'b0;
				endcase
				rxSt_nxt = srn_pkg::SRN_RX_IDLE;
			end
		end
	end

	// The originator removes its own returning transfer instead of repeating it
	assign rxOwn  = rxAccept && srcId == nodeId;
	assign rxPush = rxAccept && !rxOwn; // R7

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rxSt_r <= srn_pkg::SRN_RX_IDLE;
			upId_r <= '0;
		end else begin
			rxSt_r <= rxSt_nxt;
			if (rxTake && !rxS2_r[75]) begin
				upId_r <= rxS2_r[73:66]; // R21
			end
		end
	end

	srn_fifo #(.WIDTH(66), .DEPTH(RX_DEPTH)) u_rx_fifo (
		.clk      (sys_clk),
		.rst      (rst),
		.inValid  (rxPush),
		.inReady  (rxInReady),
		.inData   (rxS2_r[65:0]),
		.outValid (rxOutValid),
		.outReady (rxPop),
		.outData  (rxOutData),
		.count    (rxCount)
	);

	// Stop host writes above half, release only below half
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rxStop_r <= 1'b0;
		end else if (rxCount > (RXW+1)'(RX_DEPTH / 2)) begin
			rxStop_r <= 1'b1; // R12
		end else if (rxCount < (RXW+1)'(RX_DEPTH / 2)) begin
			rxStop_r <= 1'b0;
		end
	end

	assign txHalf  = txCount >= (TXW+1)'(TX_DEPTH / 2); // R9
	assign blocked = protEn && protMap[rxOutData[57:50]][rxOutData[65:58]]; // R13 R14
	assign hostCsr = hostWrAddr < `SRN_CSR_SPAN; // R23
	assign hostNet = !disc && !(addrLimit && hostWrAddr >= `SRN_NET_LIMIT); // R20 R24
	assign rxPop   = rxOutValid && txInReady; // R7

	// Arbitration: ring data ahead of host writes; host request waits while ring data moves
	always_comb begin
		txPush     = 1'b0;
		txItem     = rxOutData;
		memWe      = 1'b0;
		hostMemWe  = 1'b0;
		memA       = rxOutData[57:32];
		memD       = rxOutData[31:0];
		hostWrAck  = 1'b0;
		hostWrStop = 1'b0;
		if (rxPop) begin
			txPush = 1'b1; // R17
			memWe  = !disc && !blocked; // R14 R20
		end else if (hostWrReq) begin
			memA = hostWrAddr;
			memD = srnSwap(srn_pkg::srn_swap_t'(ctrl_r[`SRN_CTRL_SWAP]), hostWrData); // R5
			txItem = {nodeId, hostWrAddr, memD};
			if (rxStop_r) begin
				hostWrStop = 1'b1; // R12
			end else if (hostCsr || monitor) begin
				hostWrAck = 1'b1; // R19 R23
			end else if (hostNet && !txInReady) begin
				hostWrStop = 1'b1; // R11
			end else begin
				hostWrAck = 1'b1;
				hostMemWe = 1'b1;
				memWe     = 1'b1; // R8
				txPush    = hostNet; // R8
			end
		end
	end

	// Registered memory port
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			memWrEn   <= 1'b0;
			memWrAddr <= '0;
			memWrData <= '0;
		end else begin
			memWrEn   <= memWe;
			memWrAddr <= memA;
			memWrData <= memD;
		end
	end

	srn_fifo #(.WIDTH(66), .DEPTH(TX_DEPTH)) u_tx_fifo (
		.clk      (sys_clk),
		.rst      (rst),
		.inValid  (txPush),
		.inReady  (txInReady),
		.inData   (txItem),
		.outValid (txOutValid),
		.outReady (txPop),
		.outData  (txOutData),
		.count    (txCount)
	);

	// One word per link clock; in redundant mode the head is sent twice before popping
	assign txPop = txEdge && txOutValid && (!redundant || txSt_r == srn_pkg::SRN_TX_SECOND);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			txSt_r  <= srn_pkg::SRN_TX_FIRST;
			txValid <= 1'b0;
			txCopy  <= 1'b0;
			txSrcId <= '0;
			txAddr  <= '0;
			txData  <= '0;
		end else if (txEdge) begin
			txValid <= txOutValid;
			txCopy  <= redundant && txSt_r == srn_pkg::SRN_TX_SECOND; // R2
			{txSrcId, txAddr, txData} <= txOutData;
			if (txOutValid && redundant && txSt_r == srn_pkg::SRN_TX_FIRST) begin
				txSt_r <= srn_pkg::SRN_TX_SECOND; // R2
			end else begin
				txSt_r <= srn_pkg::SRN_TX_FIRST;
			end
		end
	end

	// AXI write channel: address and data held in either order, then one register write
	assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
	assign s_axi_wready  = !wHeld_r && !s_axi_bvalid;
	assign wrEn          = awHeld_r && wHeld_r && !s_axi_bvalid;
	assign wrOk          = awAddr_r <= `SRN_INITWORD_OFF && awAddr_r[1:0] == 2'b00;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			awHeld_r     <= 1'b0;
			wHeld_r      <= 1'b0;
			awAddr_r     <= '0;
			wData_r      <= '0;
			wStrb_r      <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `SRN_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
			if (wrEn) begin
				awHeld_r     <= 1'b0;
				wHeld_r      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrOk ? `SRN_RESP_OKAY : `SRN_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Control register and initiator index; reset value gives plain mirroring
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_r    <= `SRN_CTRL_RST; // R6
			initIdx_r <= '0;
		end else if (wrEn && awAddr_r == `SRN_CTRL_OFF && wStrb_r[0]) begin
			ctrl_r <= wData_r[7:0];
		end else if (wrEn && awAddr_r == `SRN_INITIDX_OFF && wStrb_r[0]) begin
			initIdx_r <= wData_r[2:0];
		end
	end

	// Protection map is plain storage, filled by software before enabling
	always_ff @(posedge sys_clk) begin
		if (wrEn && awAddr_r == `SRN_PROTWR_OFF) begin
			protMap[wData_r[15:8]][wData_r[7:0]] <= wData_r[`SRN_PW_BAR]; // R15
		end
	end

	// Sticky status flags: hardware set wins over a write-one-to-clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ownFlag_r  <= 1'b0;
			errFlag_r  <= 1'b0;
			protFlag_r <= 1'b0;
			faultId_r  <= '0;
			faultSeg_r <= '0;
		end else begin
			ownFlag_r  <= rxOwn ||
				(ownFlag_r && !(wrEn && awAddr_r == `SRN_STAT_OFF && wData_r[`SRN_ST_OWN])); // R18
			errFlag_r  <= (rxTake && rxS2_r[75]) ||
				(errFlag_r && !(wrEn && awAddr_r == `SRN_STAT_OFF && wData_r[`SRN_ST_ERR])); // R1
			protFlag_r <= (rxPop && blocked) ||
				(protFlag_r && !(wrEn && awAddr_r == `SRN_STAT_OFF && wData_r[`SRN_ST_PFLT]));
			if (rxPop && blocked) begin
				faultId_r  <= rxOutData[65:58]; // R16
				faultSeg_r <= rxOutData[57:50]; // R16
			end
		end
	end

	assign hostIrq = (errFlag_r && ctrl_r[`SRN_CTRL_ERRIE]) ||
		(protFlag_r && ctrl_r[`SRN_CTRL_PROTIE]); // R1 R16

	// Initiator list: software word write first, ring sighting ORed last so it wins
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			initList_r <= '0;
		end else begin
			logic [255:0] nxt;
			nxt = initList_r;
			if (wrEn && awAddr_r == `SRN_INITWORD_OFF) begin
				nxt[initIdx_r*32 +: 32] = srnMerge(initList_r[initIdx_r*32 +: 32], wData_r, wStrb_r);
			end
			if (rxPush) begin
				nxt[srcId] = 1'b1; // R22
			end
			initList_r <= nxt;
		end
	end

	// Read data mux
	assign stWord = {8'h0, upId_r, nodeId, 3'b000, protFlag_r, errFlag_r, ownFlag_r,
		rxStop_r, txHalf}; // R9 R21
	always_comb begin
		unique case (s_axi_araddr)
			`SRN_CTRL_OFF:     rdWord = {24'h0, ctrl_r};
			`SRN_STAT_OFF:     rdWord = stWord;
			`SRN_FAULT_OFF:    rdWord = {16'h0, faultSeg_r, faultId_r};
			`SRN_INITIDX_OFF:  rdWord = {29'h0, initIdx_r};
			`SRN_INITWORD_OFF: rdWord = initList_r[initIdx_r*32 +: 32];
			default:           rdWord = 32'h0;
		endcase
	end

	// AXI read channel: one cycle to answer, held until rready
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= `SRN_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rdWord;
			s_axi_rresp  <= (s_axi_araddr <= `SRN_INITWORD_OFF && s_axi_araddr[1:0] == 2'b00)
				? `SRN_RESP_OKAY : `SRN_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	chk_err_drop: assert property (rxTake && rxS2_r[75] && !redundant |-> !rxPush ##1 errFlag_r) // R1
		else $error("erroneous transfer not dropped");
	chk_red_twice: assert property (txPop && redundant |=> txValid && txCopy) // R2
		else $error("second copy not sent");
	chk_red_skip: assert property (rxTake && rxS2_r[74] && rxSt_r == srn_pkg::SRN_RX_SKIP2 |-> !rxPush) // R3
		else $error("duplicate of good copy accepted");
	chk_both_bad: assert property (rxTake && rxS2_r[74] && rxS2_r[75] |-> !rxPush) // R4
		else $error("bad second copy accepted");
	chk_tx_full: assert property (hostWrReq && !rxPop && !rxStop_r && !hostCsr && !monitor && hostNet
		&& !txInReady |-> hostWrStop ##1 !memWrEn) // R11
		else $error("write taken with TX FIFO full");
	chk_rx_half: assert property (rxStop_r && hostWrReq |-> !hostWrAck && !hostMemWe) // R12
		else $error("host write taken while RX over half");
	chk_forward: assert property (rxPop |-> txPush ##1 (memWrEn == $past(!disc && !blocked))) // R17
		else $error("ring item not forwarded or wrong memory update");
	chk_monitor: assert property (monitor && hostWrReq |-> !hostMemWe && !(txPush && !rxPop)) // R19
		else $error("host write passed in monitor mode");
	chk_own_flag: assert property (rxOwn |=> ownFlag_r && !$past(rxPush)) // R18
		else $error("own data flag not set");
	chk_tx_half: assert property (txCount >= (TXW+1)'(TX_DEPTH / 2) |-> stWord[`SRN_ST_TXHALF]) // R9
		else $error("half flag missing");

	cov_red_recover: cover property (rxSt_r == srn_pkg::SRN_RX_WAIT2 && rxTake && rxPush);
	cov_prot_fault:  cover property (rxPop && blocked);
	cov_tx_stop:     cover property (hostWrStop && !rxStop_r);
	cov_own_return:  cover property (rxOwn);
endmodule // srn_node_core
`default_nettype wire

// ---- shared/srn_params.svh ----
// Register offsets, field positions, reset values and address limits
`ifndef SRN_PARAMS_SVH
`define SRN_PARAMS_SVH
`define SRN_CTRL_OFF     8'h00
`define SRN_STAT_OFF     8'h04
`define SRN_FAULT_OFF    8'h08
`define SRN_PROTWR_OFF   8'h0c
`define SRN_INITIDX_OFF  8'h10
`define SRN_INITWORD_OFF 8'h14
`define SRN_CTRL_RST     8'h00
`define SRN_CTRL_RED     0
`define SRN_CTRL_SWAP    2:1
`define SRN_CTRL_MON     3
`define SRN_CTRL_DISC    4
`define SRN_CTRL_PROT    5
`define SRN_CTRL_ERRIE   6
`define SRN_CTRL_PROTIE  7
`define SRN_ST_TXHALF    0
`define SRN_ST_RXHALF    1
`define SRN_ST_OWN       2
`define SRN_ST_ERR       3
`define SRN_ST_PFLT      4
`define SRN_PW_BAR       16
`define SRN_CSR_SPAN     26'h0000040
`define SRN_NET_LIMIT    26'h1000000
`define SRN_RESP_OKAY    2'h0
`define SRN_RESP_SLVERR  2'h2
`endif

// ---- shared/srn_pkg.sv ----
// Types shared by the ring node core
package srn_pkg;
	typedef enum logic [1:0] {
		SRN_SW_NONE = 2'b00,
		SRN_SW_BYTE = 2'b01,
		SRN_SW_WORD = 2'b10,
		SRN_SW_BOTH = 2'b11
	} srn_swap_t;
	typedef enum logic [1:0] {
		SRN_RX_IDLE  = 2'b00,
		SRN_RX_WAIT2 = 2'b01,
		SRN_RX_SKIP2 = 2'b10
	} srn_rxst_t;
	typedef enum logic {
		SRN_TX_FIRST  = 1'b0,
		SRN_TX_SECOND = 1'b1
	} srn_txst_t;
endpackage

// ---- rtl/srn_fifo.sv ----
// Synchronous FIFO with occupancy count
`timescale 1ns/1ns
`default_nettype none
module srn_fifo #(
	parameter int WIDTH = 66,
	parameter int DEPTH = 64,
	localparam int AW = $clog2(DEPTH)
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData,
	output logic      [AW:0]      count
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_r;
	logic [AW-1:0]    rdPtr_r;
	logic [AW:0]      count_r;
	logic             push;
	logic             pop;

	// Pointers wrap naturally, so depth must be a power of two
	if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad
		$error("srn_fifo: DEPTH must be a power of two, at least 4");
	end

	// Handshake terms
	assign inReady  = count_r != (AW+1)'(DEPTH);
	assign outValid = count_r != '0;
	assign outData  = mem[rdPtr_r];
	assign count    = count_r;
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	// Storage is not reset; only the pointers and the count carry reset state
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_r] <= inData;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else begin
			wrPtr_r <= wrPtr_r + AW'(push);
			rdPtr_r <= rdPtr_r + AW'(pop);
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // srn_fifo
`default_nettype wire

// ---- bench/srn_ring_peer.sv ----
// Ring neighbours: upstream sender and downstream receiver of the node
`timescale 1ns/1ns
`default_nettype none
module srn_ring_peer (
	output logic             linkRxClk,
	output logic             rxValid,
	output logic             rxErr,
	output logic             rxCopy,
	output logic      [7:0]  rxHopId,
	output logic      [7:0]  rxSrcId,
	output logic      [25:0] rxAddr,
	output logic      [31:0] rxData,
	output logic             linkTxClk,
	input  wire logic        txRun,
	input  wire logic        txValid,
	input  wire logic [31:0] txData
);
	int          txCnt = 0;
	logic [31:0] txLast;
	// Receive clock idles low; the downstream clock runs only while txRun is set
	initial begin
		{linkRxClk, rxValid, rxErr, rxCopy, rxHopId, rxSrcId, rxAddr, rxData} = '0;
		linkTxClk = 1'b0;
		forever begin
			#62 linkTxClk = txRun;
			#63 linkTxClk = 1'b0;
		end
	end
	// One word per link period, bundle stable across the rising edge
	task automatic send(input logic e, c, input logic [7:0] h, s, input logic [25:0] a,
			input logic [31:0] d);
		{rxValid, rxErr, rxCopy, rxHopId, rxSrcId, rxAddr, rxData} = {1'b1, e, c, h, s, a, d};
		#62 linkRxClk = 1'b1;
		#63 linkRxClk = 1'b0;
		// Released lines show inverted data so stale values cannot pass
		{rxValid, rxErr, rxCopy, rxHopId, rxSrcId, rxAddr, rxData} = {1'b0, ~{e, c, h, s, a, d}};
	endtask
	// A word shown after one rise is taken at the next rise
	always @(posedge linkTxClk) if (txValid === 1'b1) begin
		txCnt++;
		txLast = txData;
	end
endmodule // srn_ring_peer
`default_nettype wire

// ---- bench/srn_node_core_bench.sv ----
// Self-checking bench for the ring node core
`timescale 1ns/1ns
`default_nettype none
`include "srn_params.svh"
module srn_node_core_bench;
	typedef struct packed {
		logic [7:0]  ctrl;
		logic [25:0] addr;
		logic [31:0] mem;
		logic [1:0]  memN;
		logic [1:0]  txN;
	} srn_row_t;
	logic        sys_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, hostWrReq, hostWrAck, hostWrStop, addrLimitPin, linkRxClk;
	logic        rxValid, rxErr, rxCopy, linkTxClk, txValid, memWrEn, hostIrq, txRun, st;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic [3:0]  s_axi_wstrb;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, nodeIdPin, rxHopId, rxSrcId;
	logic [25:0] hostWrAddr, rxAddr, memWrAddr, memA;
	logic [31:0] s_axi_wdata, s_axi_rdata, hostWrData, rxData, txData, memWrData, memD, rd;
	int          err_total = 0, num_checks = 0, memCnt = 0, mc, tc;
	// Host data is always 11223344; expected lanes follow the swap setting
	srn_row_t    rows [9] = '{
		'{8'h00, 26'h0000100, 32'h11223344, 2'h1, 2'h1},
		'{8'h02, 26'h0000104, 32'h22114433, 2'h1, 2'h1},
		'{8'h04, 26'h0000108, 32'h33441122, 2'h1, 2'h1},
		'{8'h06, 26'h000010c, 32'h44332211, 2'h1, 2'h1},
		'{8'h00, 26'h000003c, 32'h00000000, 2'h0, 2'h0},
		'{8'h08, 26'h0000110, 32'h00000000, 2'h0, 2'h0},
		'{8'h10, 26'h0000114, 32'h11223344, 2'h1, 2'h0},
		'{8'h01, 26'h0000118, 32'h11223344, 2'h1, 2'h2},
		'{8'h00, 26'h1000000, 32'h11223344, 2'h1, 2'h0}};
	srn_node_core #(.TX_DEPTH(8), .RX_DEPTH(8)) u_dut (
		.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
		.s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
		.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
		.s_axi_rdata, .s_axi_rresp, .hostWrReq, .hostWrAddr, .hostWrData, .hostWrAck,
		.hostWrStop, .nodeIdPin, .addrLimitPin, .linkRxClk, .rxValid, .rxErr, .rxCopy,
		.rxHopId, .rxSrcId, .rxAddr, .rxData, .linkTxClk, .txValid, .txCopy(), .txSrcId(),
		.txAddr(), .txData, .memWrEn, .memWrAddr, .memWrData, .hostIrq);
	srn_ring_peer u_peer (.linkRxClk, .rxValid, .rxErr, .rxCopy, .rxHopId, .rxSrcId,
		.rxAddr, .rxData, .linkTxClk, .txRun, .txValid, .txData);
	// System clock, 8 ns
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// Memory port sampled mid-cycle, clear of the launching edge
	always @(negedge sys_clk) if (memWrEn === 1'b1) begin
		memCnt++;
		memD = memWrData;
		memA = memWrAddr;
	end
	task automatic chk(input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Ready is read mid-cycle so the handshake never races the edge
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w, b;
		{aw, w, b} = 3'h0;
		@(posedge sys_clk);
		s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!b) begin
			@(negedge sys_clk);
			b = aw && w && s_axi_bvalid;
			r = s_axi_bresp;
			aw = aw | (s_axi_awvalid & s_axi_awready);
			w = w | (s_axi_wvalid & s_axi_wready);
			@(posedge sys_clk);
			if (aw) s_axi_awvalid <= 0;
			if (w) s_axi_wvalid <= 0;
		end
		s_axi_bready <= 0;
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar, v;
		{ar, v} = 2'h0;
		@(posedge sys_clk);
		s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
		while (!v) begin
			@(negedge sys_clk);
			v = ar && s_axi_rvalid;
			ar = ar | s_axi_arready;
			{d, r} = {s_axi_rdata, s_axi_rresp};
			@(posedge sys_clk);
			if (ar) s_axi_arvalid <= 0;
		end
		s_axi_rready <= 0;
	endtask
	// Request held until acknowledged or stopped
	task automatic hw(input logic [25:0] a, input logic [31:0] d, output logic s);
		logic dn;
		dn = 1'b0;
		@(posedge sys_clk);
		hostWrReq <= 1; hostWrAddr <= a; hostWrData <= d;
		while (!dn) begin
			@(negedge sys_clk);
			dn = hostWrAck | hostWrStop;
			s = hostWrStop;
			@(posedge sys_clk);
		end
		hostWrReq <= 0;
	endtask
	// One transfer from upstream, one or two copies, then count the effects
	task automatic ring(input logic e0, e1, two, input logic [7:0] s, input logic [25:0] a,
			input int nm, nt);
		mc = memCnt;
		tc = u_peer.txCnt;
		u_peer.send(e0, 1'b0, 8'h07, s, a, 32'ha5a5a5a5);
		if (two) u_peer.send(e1, 1'b1, 8'h07, s, a, 32'ha5a5a5a5);
		repeat (100) @(posedge sys_clk);
		chk(memCnt - mc, nm);
		chk(u_peer.txCnt - tc, nt);
		if (nm > 0) chk(memD, 32'ha5a5a5a5);
		if (nm > 0) chk(memA, a);
		$display("ring test from %h done", s);
	endtask
	// Watchdog: the whole sequence needs well under 10,000 cycles
	initial begin
		#200000;
		err_total++;
		conclude;
	end
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, hostWrReq, hostWrAddr, hostWrData} = '0;
		{s_axi_wstrb, nodeIdPin, addrLimitPin, rst, txRun} = {4'hf, 8'h21, 3'h7};
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		axr(`SRN_CTRL_OFF, rd, rs);
		chk(rd, 32'h0);
		$display("reset test done");
		foreach (rows[i]) begin
			axw(`SRN_CTRL_OFF, {24'h0, rows[i].ctrl}, rs);
			mc = memCnt;
			tc = u_peer.txCnt;
			hw(rows[i].addr, 32'h11223344, st);
			repeat (100) @(posedge sys_clk);
			chk(memCnt - mc, rows[i].memN);
			if (rows[i].memN > 0) chk(memD, rows[i].mem);
			if (rows[i].memN > 0) chk(memA, rows[i].addr);
			chk(u_peer.txCnt - tc, rows[i].txN);
			if (rows[i].txN > 0) chk(u_peer.txLast, rows[i].mem);
			$display("row %0d done", i);
		end
		axw(`SRN_CTRL_OFF, 32'h0, rs);
		ring(0, 0, 0, 8'h05, 26'h200, 1, 1);
		axr(`SRN_STAT_OFF, rd, rs);
		chk(rd[23:8], 16'h0721);
		axw(`SRN_INITIDX_OFF, 32'h0, rs);
		axr(`SRN_INITWORD_OFF, rd, rs);
		chk(rd[5], 1'b1);
		axw(`SRN_INITWORD_OFF, 32'h0, rs);
		axr(`SRN_INITWORD_OFF, rd, rs);
		chk(rd, 32'h0);
		axw(`SRN_CTRL_OFF, 32'h40, rs);
		ring(1, 0, 0, 8'h05, 26'h204, 0, 0);
		chk(hostIrq, 1'b1);
		axw(`SRN_STAT_OFF, 32'h8, rs);
		chk(hostIrq, 1'b0);
		ring(0, 0, 0, 8'h21, 26'h208, 0, 0);
		axr(`SRN_STAT_OFF, rd, rs);
		chk(rd[2], 1'b1);
		axw(`SRN_CTRL_OFF, 32'h1, rs);
		ring(1, 0, 1, 8'h05, 26'h20c, 1, 2);
		ring(1, 1, 1, 8'h05, 26'h210, 0, 0);
		ring(0, 0, 1, 8'h05, 26'h214, 1, 2);
		axw(`SRN_CTRL_OFF, 32'h0, rs);
		axw(`SRN_PROTWR_OFF, 32'h00010105, rs);
		axw(`SRN_PROTWR_OFF, 32'h00000106, rs);
		axw(`SRN_CTRL_OFF, 32'ha0, rs);
		ring(0, 0, 0, 8'h05, 26'h0040000, 0, 1);
		axr(`SRN_FAULT_OFF, rd, rs);
		chk(rd[15:0], 16'h0105);
		chk(hostIrq, 1'b1);
		ring(0, 0, 0, 8'h06, 26'h0040004, 1, 1);
		axw(`SRN_CTRL_OFF, 32'h10, rs);
		ring(0, 0, 0, 8'h06, 26'h300, 0, 1);
		axr(8'h20, rd, rs);
		chk(rd, 32'h0);
		chk(rs, 2'h2);
		axw(8'h02, 32'h0, rs);
		chk(rs, 2'h2);
		$display("register tests done");
		// Downstream stalled: the burst ignores the half-full flag to reach a full queue
		axw(`SRN_CTRL_OFF, 32'h0, rs);
		txRun <= 1'b0;
		st = 1'b0;
		for (int k = 0; k < 12 && !st; k++) hw(26'h400 + 26'(4 * k), 32'h1, st);
		chk(st, 1'b1);
		axr(`SRN_STAT_OFF, rd, rs);
		chk(rd[0], 1'b1);
		for (int k = 0; k < 6; k++) u_peer.send(0, 0, 8'h07, 8'h05, 26'h500, 32'h2);
		repeat (20) @(posedge sys_clk);
		axr(`SRN_STAT_OFF, rd, rs);
		chk(rd[1], 1'b1);
		hw(26'h600, 32'h3, st);
		chk(st, 1'b1);
		$display("flow control test done");
		conclude;
	end
endmodule // srn_node_core_bench
`default_nettype wire
